// ==== hdl/rbs_pkg.sv ====
// Constants and types for the broadcast-data block synchroniser.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
package rbs_pkg;
    // ========================================
    // Check code
    localparam logic [9:0] GEN_POLY    = 10'h1B9;
    localparam logic [9:0] OFF_A       = 10'h0FC;
    localparam logic [9:0] OFF_B       = 10'h198;
    localparam logic [9:0] OFF_C       = 10'h168;
    localparam logic [9:0] OFF_CP      = 10'h350;
    localparam logic [9:0] OFF_D       = 10'h1B4;
    localparam int         BLK_BITS    = 26;
    localparam int         DATA_BITS   = 16;
    localparam int         CHK_BITS    = 10;
    localparam int         BURST_BITS  = 5;
    localparam logic [2:0] MISS_LIMIT  = 3'h5;
    localparam logic [1:0] IDX_B       = 2'h1;
    localparam logic [1:0] IDX_C       = 2'h2;

    // ========================================
    // Timing
    localparam int SYS_PERIOD_NS = 10;
    localparam int OUT_HALF_NS   = 40;
    localparam int OUT_HALF_CYC  = (OUT_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

    // ========================================
    // Register map
    localparam logic [7:0] ADDR_STATUS = 8'h00;
    localparam logic [7:0] ADDR_MASK   = 8'h04;
    localparam logic [7:0] ADDR_STATE  = 8'h08;
    localparam logic [7:0] ADDR_DATA   = 8'h0C;
    localparam int         EV_GAIN     = 0;
    localparam int         EV_LOSS     = 1;
    localparam int         EV_FIX      = 2;
    localparam int         EV_BAD      = 3;
    localparam int         EV_BITS     = 4;

    // ========================================
    // Types
    typedef enum logic [2:0] {
        ST_HUNT  = 3'b001,
        ST_CHECK = 3'b010,
        ST_LOCK  = 3'b100
    } rbs_fsm_t;
endpackage

// ==== hdl/rbs_core.sv ====
// Block synchroniser, burst corrector and serial output with APB status.
// Assumes link clock and all select pins are asynchronous to SYS_CLK.
`timescale 1ns/1ns
module rbs_core #(
    parameter int HALF_CYC = rbs_pkg::OUT_HALF_CYC
) (
    // System
    input  wire logic        SYS_CLK,
    input  wire logic        RST,
    input  wire logic        CHIP_RESET_N,
    // Demodulator link
    input  wire logic        LINK_CLK,
    input  wire logic        LINK_DATA,
    // Mode pins
    input  wire logic        FIX_ENABLE_SELECT,
    input  wire logic        OUT_EDGE_POLARITY_SELECT,
    input  wire logic        MARKER_SECOND_ONLY,
    // Serial output
    output logic             SER_DATA,
    output logic             SER_CLK,
    output logic             SER_START,
    // Open-drain flags
    output logic             RECV_O,
    output logic             RECV_OE,
    output logic             FIX_O,
    output logic             FIX_OE,
    output logic             UNFIX_O,
    output logic             UNFIX_OE,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             IRQ
);
    // ========================================
    // State
    typedef struct packed {
        logic [2:0]            clk_s;
        logic [1:0]            dat_s;
        logic [1:0]            crst_s;
        logic [1:0]            fsel_s;
        logic [1:0]            esel_s;
        logic [1:0]            msel_s;
        logic [25:0]           shreg;
        rbs_pkg::rbs_fsm_t     fsm;
        logic [4:0]            bitcnt;
        logic [1:0]            idx;
        logic [2:0]            miss;
        logic                  busy;
        logic                  trail;
        logic                  half;
        logic [3:0]            obit;
        logic [7:0]            div;
        logic                  mark;
        logic [15:0]           odata;
        logic                  do_ff;
        logic                  dclk_ff;
        logic                  dstart_ff;
        logic                  fix_ff;
        logic                  unfix_ff;
        logic [3:0]            status;
        logic [3:0]            mask;
        logic [15:0]           last;
        logic [31:0]           prdata;
    } rbs_st_t;

    rbs_st_t st_ff;
    rbs_st_t nxt_st;

    function automatic rbs_st_t rst_val();
        rbs_st_t r;
        r           = '0;
        r.fsm       = rbs_pkg::ST_HUNT;
        r.do_ff     = 1'b1;
        r.dclk_ff   = 1'b1;
        r.dstart_ff = 1'b1;
        return r;
    endfunction

    // ========================================
    // Check arithmetic
    function automatic logic [9:0] mod26(input logic [25:0] w);
        logic [9:0] r;
        logic       fb;
        r = '0;
        for (int i = 25; i >= 0; i--) begin
            fb = r[9];
            r  = {r[8:0], w[i]};
            if (fb) begin
                r = r ^ rbs_pkg::GEN_POLY;
            end
        end
        return r;
    endfunction

    function automatic logic [26:0] burst_find(input logic [9:0] syn);
        logic [26:0] res;
        logic [30:0] e;
        res = '0;
        for (int p = 0; p < rbs_pkg::BLK_BITS; p++) begin
            for (int q = 0; q < 16; q++) begin
                e = 31'({4'(q), 1'b1}) << p;
                if (!res[26] && mod26(e[25:0]) == syn) begin
                    res = {1'b1, e[25:0]};
                end
            end
        end
        return res;
    endfunction

    function automatic logic [9:0] off_of(input logic [1:0] i);
        case (i)
            2'h0:    off_of = rbs_pkg::OFF_A;
            2'h1:    off_of = rbs_pkg::OFF_B;
            2'h2:    off_of = rbs_pkg::OFF_C;
            default: off_of = rbs_pkg::OFF_D;
        endcase
    endfunction

    // ========================================
    // Next state
    logic        new_bit;
    logic        boundary;
    logic [9:0]  syn;
    logic [9:0]  exp_off;
    logic        exact;
    logic [26:0] fix_res;
    logic        fix_en;
    logic        acc;
    logic        rd_status;
    logic [3:0]  ev;
    logic        launch;
    logic        bad;
    logic        mark_now;

    always_comb begin
        nxt_st   = st_ff;
        ev       = '0;
        launch   = 1'b0;
        bad      = 1'b0;
        fix_res  = '0;
        nxt_st.clk_s  = {st_ff.clk_s[1:0], LINK_CLK};
        nxt_st.dat_s  = {st_ff.dat_s[0], LINK_DATA};
        nxt_st.crst_s = {st_ff.crst_s[0], CHIP_RESET_N};
        nxt_st.fsel_s = {st_ff.fsel_s[0], FIX_ENABLE_SELECT};
        nxt_st.esel_s = {st_ff.esel_s[0], OUT_EDGE_POLARITY_SELECT};
        nxt_st.msel_s = {st_ff.msel_s[0], MARKER_SECOND_ONLY};
        fix_en   = st_ff.fsel_s[1];
        new_bit  = st_ff.clk_s[1] & ~st_ff.clk_s[2];
        boundary = new_bit && st_ff.bitcnt == 5'(rbs_pkg::BLK_BITS - 1);
        syn      = mod26(st_ff.shreg);
        exp_off  = off_of(st_ff.idx);
        exact    = syn == exp_off ||
                   (st_ff.idx == rbs_pkg::IDX_C && syn == rbs_pkg::OFF_CP);
        if (new_bit) begin
            nxt_st.shreg = {st_ff.shreg[24:0], st_ff.dat_s[1]};
        end

        // ========================================
        // Synchroniser
        case (st_ff.fsm)
            rbs_pkg::ST_HUNT: begin
                nxt_st.bitcnt = '0;
                if (new_bit) begin
                    nxt_st.fsm = rbs_pkg::ST_CHECK;
                    if (syn == rbs_pkg::OFF_A) begin
                        nxt_st.idx = 2'h1;
                    end else if (syn == rbs_pkg::OFF_B) begin
                        nxt_st.idx = 2'h2;
                    end else if (syn == rbs_pkg::OFF_C || syn == rbs_pkg::OFF_CP) begin
                        nxt_st.idx = 2'h3;
                    end else if (syn == rbs_pkg::OFF_D) begin
                        nxt_st.idx = 2'h0;
                    end else begin
                        nxt_st.fsm = rbs_pkg::ST_HUNT;
                    end
                end
            end
            rbs_pkg::ST_CHECK, rbs_pkg::ST_LOCK: begin
                if (new_bit) begin
                    nxt_st.bitcnt = st_ff.bitcnt + 5'h1;
                end
                if (boundary) begin
                    nxt_st.bitcnt = '0;
                    nxt_st.idx    = st_ff.idx + 2'h1;
                    if (!exact && fix_en) begin
                        fix_res = burst_find(syn ^ exp_off);
                    end
                    bad = !exact && !fix_res[26];
                    if (st_ff.fsm == rbs_pkg::ST_CHECK) begin
                        if (exact) begin
                            nxt_st.fsm  = rbs_pkg::ST_LOCK;
                            ev[rbs_pkg::EV_GAIN] = 1'b1;
                            launch = 1'b1;
                        end else begin
                            nxt_st.fsm = rbs_pkg::ST_HUNT;
                        end
                    end else if (!bad) begin
                        nxt_st.miss = '0;
                        launch = 1'b1;
                    end else if (st_ff.miss + 3'h1 == rbs_pkg::MISS_LIMIT) begin
                        nxt_st.fsm  = rbs_pkg::ST_HUNT;
                        nxt_st.miss = '0;
                        ev[rbs_pkg::EV_LOSS] = 1'b1;
                    end else begin
                        nxt_st.miss = st_ff.miss + 3'h1;
                        launch = 1'b1;
                    end
                end
            end
            default: nxt_st.fsm = rbs_pkg::ST_HUNT;
        endcase

        // ========================================
        // Serial output
        mark_now = !st_ff.msel_s[1] || st_ff.mark;
        if (launch) begin
            nxt_st.odata = st_ff.shreg[25:10] ^ fix_res[25:10];
            nxt_st.last  = st_ff.shreg[25:10] ^ fix_res[25:10];
            nxt_st.mark  = st_ff.idx == rbs_pkg::IDX_B;
            nxt_st.busy  = 1'b1;
            nxt_st.trail = 1'b0;
            nxt_st.half  = 1'b0;
            nxt_st.obit  = '0;
            nxt_st.div   = '0;
            nxt_st.dclk_ff = 1'b0;
            nxt_st.fix_ff   = fix_en && (fix_res[26] || bad);
            nxt_st.unfix_ff = bad;
            ev[rbs_pkg::EV_FIX] = fix_res[26];
            ev[rbs_pkg::EV_BAD] = bad;
            if (!st_ff.esel_s[1]) begin
                nxt_st.do_ff = st_ff.shreg[25];
                nxt_st.dstart_ff = !(!st_ff.msel_s[1] ||
                                     st_ff.idx == rbs_pkg::IDX_B);
            end
        end else if (st_ff.busy) begin
            if (st_ff.div != 8'(HALF_CYC - 1)) begin
                nxt_st.div = st_ff.div + 8'h1;
            end else begin
                nxt_st.div = '0;
                if (st_ff.trail) begin
                    nxt_st.busy      = 1'b0;
                    nxt_st.dclk_ff   = 1'b1;
                    nxt_st.do_ff     = 1'b1;
                    nxt_st.dstart_ff = 1'b1;
                end else if (!st_ff.half) begin
                    nxt_st.half    = 1'b1;
                    nxt_st.dclk_ff = 1'b1;
                    if (st_ff.esel_s[1]) begin
                        nxt_st.do_ff = st_ff.odata[4'hF - st_ff.obit];
                        nxt_st.dstart_ff = !(st_ff.obit == 4'h0 && mark_now);
                    end
                end else if (st_ff.obit == 4'(rbs_pkg::DATA_BITS - 1)) begin
                    if (st_ff.esel_s[1]) begin
                        nxt_st.trail   = 1'b1;
                        nxt_st.dclk_ff = 1'b0;
                    end else begin
                        nxt_st.busy      = 1'b0;
                        nxt_st.do_ff     = 1'b1;
                        nxt_st.dstart_ff = 1'b1;
                    end
                end else begin
                    nxt_st.half    = 1'b0;
                    nxt_st.obit    = st_ff.obit + 4'h1;
                    nxt_st.dclk_ff = 1'b0;
                    if (!st_ff.esel_s[1]) begin
                        nxt_st.do_ff = st_ff.odata[4'hE - st_ff.obit];
                        nxt_st.dstart_ff = 1'b1;
                    end
                end
            end
        end
        if (nxt_st.fsm == rbs_pkg::ST_HUNT) begin
            nxt_st.fix_ff   = 1'b0;
            nxt_st.unfix_ff = 1'b0;
        end

        // ========================================
        // Register port
        acc       = PSEL && PENABLE;
        rd_status = acc && !PWRITE && PADDR == rbs_pkg::ADDR_STATUS;
        nxt_st.status = (rd_status ? st_ff.status & ~st_ff.prdata[3:0] : st_ff.status) | ev;
        if (acc && PWRITE && PADDR == rbs_pkg::ADDR_MASK) begin
            nxt_st.mask = PWDATA[3:0];
        end
        if (PSEL && !PENABLE) begin
            case (PADDR)
                rbs_pkg::ADDR_STATUS: nxt_st.prdata = {28'h0, st_ff.status};
                rbs_pkg::ADDR_MASK:   nxt_st.prdata = {28'h0, st_ff.mask};
                rbs_pkg::ADDR_STATE:  nxt_st.prdata = {22'h0, st_ff.busy, st_ff.miss,
                                                      st_ff.idx, st_ff.fsm, fix_en};
                rbs_pkg::ADDR_DATA:   nxt_st.prdata = {16'h0, st_ff.last};
                default:              nxt_st.prdata = 32'h0;
            endcase
        end
        if (!st_ff.crst_s[1]) begin
            nxt_st        = rst_val();
            nxt_st.clk_s  = st_ff.clk_s;
            nxt_st.dat_s  = st_ff.dat_s;
            nxt_st.crst_s = {st_ff.crst_s[0], CHIP_RESET_N};
            nxt_st.fsel_s = st_ff.fsel_s;
            nxt_st.esel_s = st_ff.esel_s;
            nxt_st.msel_s = st_ff.msel_s;
            nxt_st.mask   = st_ff.mask;
            nxt_st.status = st_ff.status;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            st_ff <= rst_val();
            st_ff.crst_s <= 2'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ========================================
    // Outputs
    assign SER_DATA  = st_ff.do_ff;
    assign SER_CLK   = st_ff.dclk_ff;
    assign SER_START = st_ff.dstart_ff;
    assign RECV_O    = 1'b0;
    assign RECV_OE   = st_ff.busy;
    assign FIX_O     = 1'b0;
    assign FIX_OE    = st_ff.fix_ff;
    assign UNFIX_O   = 1'b0;
    assign UNFIX_OE  = st_ff.unfix_ff;
    assign PRDATA    = st_ff.prdata;
    assign PREADY    = 1'b1;
    assign PSLVERR   = PSEL && PENABLE && PADDR != rbs_pkg::ADDR_STATUS &&
                       PADDR != rbs_pkg::ADDR_MASK && PADDR != rbs_pkg::ADDR_STATE &&
                       PADDR != rbs_pkg::ADDR_DATA;
    assign IRQ       = |(st_ff.status & st_ff.mask);
endmodule

// ==== bench/rbs_core_props.sv ====
// Assertion checker for the serial output, status flags and APB error.
// Assumes binding onto rbs_core with default HALF_CYC; samples on SYS_CLK.
`timescale 1ns/1ns
module rbs_core_props (
    // System
    input wire logic       SYS_CLK,
    input wire logic       RST,
    input wire logic       CHIP_RESET_N,
    // Mode pins
    input wire logic       FIX_ENABLE_SELECT,
    input wire logic       OUT_EDGE_POLARITY_SELECT,
    // Serial output and flags
    input wire logic       SER_DATA,
    input wire logic       SER_CLK,
    input wire logic       SER_START,
    input wire logic       RECV_OE,
    input wire logic       FIX_OE,
    input wire logic       UNFIX_OE,
    // APB
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic [7:0] PADDR,
    input wire logic       PSLVERR
);
    // ========================================
    // Properties
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    property p_rst_idle;
        disable iff (1'b0)
        RST |=> SER_CLK && SER_DATA && SER_START && !RECV_OE && !FIX_OE && !UNFIX_OE;
    endproperty
    property p_chip_idle; !CHIP_RESET_N [*5] |-> SER_CLK && SER_START && !RECV_OE; endproperty
    property p_unfix_fix; $rose(UNFIX_OE) |-> FIX_OE == FIX_ENABLE_SELECT; endproperty
    property p_fix_off; !FIX_ENABLE_SELECT [*4] |-> !$rose(FIX_OE); endproperty
    property p_flag_launch;
        $rose(FIX_OE) || $rose(UNFIX_OE) |-> $rose(RECV_OE) && $fell(SER_CLK);
    endproperty
    property p_mark_len; $fell(SER_START) |-> !SER_START [*8] ##1 SER_START; endproperty
    property p_mark_pol0;
        $fell(SER_START) && !OUT_EDGE_POLARITY_SELECT |-> $rose(RECV_OE);
    endproperty
    property p_pol0_edge;
        !OUT_EDGE_POLARITY_SELECT && RECV_OE && $changed(SER_DATA) |-> $fell(SER_CLK);
    endproperty
    property p_pol1_edge;
        OUT_EDGE_POLARITY_SELECT && RECV_OE && $changed(SER_DATA) |-> $rose(SER_CLK);
    endproperty
    property p_idle_lines; !RECV_OE |-> SER_CLK && SER_DATA && SER_START; endproperty
    property p_apb_err; PSEL && PENABLE && PADDR > 8'h0F |-> PSLVERR; endproperty
    // ========================================
    // Assertions
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    a_chip_idle: assert property (p_chip_idle) else $error("chip reset not idle");
    a_unfix_fix: assert property (p_unfix_fix) else $error("fix flag wrong");
    a_fix_off: assert property (p_fix_off) else $error("fix flag while off");
    a_flag_launch: assert property (p_flag_launch) else $error("flag off boundary");
    a_mark_len: assert property (p_mark_len) else $error("marker length");
    a_mark_pol0: assert property (p_mark_pol0) else $error("marker not at start");
    a_pol0_edge: assert property (p_pol0_edge) else $error("data not on fall");
    a_pol1_edge: assert property (p_pol1_edge) else $error("data not on rise");
    a_idle_lines: assert property (p_idle_lines) else $error("lines not idle");
    a_apb_err: assert property (p_apb_err) else $error("no slave error");
    c_mark_pol1: cover property ($fell(SER_START) && OUT_EDGE_POLARITY_SELECT);
    c_fixed: cover property ($rose(FIX_OE) && !UNFIX_OE);
    c_unfixed: cover property ($rose(UNFIX_OE));
endmodule
bind rbs_core rbs_core_props u_props (.SYS_CLK(SYS_CLK), .RST(RST),
    .CHIP_RESET_N(CHIP_RESET_N), .FIX_ENABLE_SELECT(FIX_ENABLE_SELECT),
    .OUT_EDGE_POLARITY_SELECT(OUT_EDGE_POLARITY_SELECT), .SER_DATA(SER_DATA),
    .SER_CLK(SER_CLK), .SER_START(SER_START), .RECV_OE(RECV_OE), .FIX_OE(FIX_OE),
    .UNFIX_OE(UNFIX_OE), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PSLVERR(PSLVERR));

// ==== bench/rbs_demod_model.sv ====
// Demodulator model: bit clock and data, one 26-bit block per call, MSB first.
// Assumes back-to-back calls for a continuous stream; clock stands low between.
`timescale 1ns/1ns
module rbs_demod_model (
    // Link
    output logic link_clk,
    output logic link_data
);
    // ========================================
    // Bit stream
    initial begin
        link_clk = 1'b0;
        link_data = 1'b0;
    end
    task automatic tick(input logic b);
        link_data = b;
        #62;
        link_clk = 1'b1;
        #63;
        link_clk = 1'b0;
    endtask
    task automatic send(input logic [25:0] w);
        for (int i = 25; i >= 0; i--) begin
            tick(w[i]);
        end
        link_data = ~w[0];
    endtask
endmodule

// ==== bench/test_rds_block_sync_correct_output.sv ====
// Bench: link blocks in, serial blocks captured and compared, APB status.
// Assumes rbs_core with default HALF_CYC and the demodulator model.
`timescale 1ns/1ns
module test_rds_block_sync_correct_output;
    // ========================================
    // Signals
    logic        sys_clk, rst, chip_rst_n, fix, pol, mark, link_clk, link_data;
    logic        ser_data, ser_clk, ser_start, recv_o, recv_oe, fix_o, fix_oe, unfix_o;
    logic        unfix_oe, psel, penable, pwrite, pready, pslverr, irq, er, mk, pclk, poe;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [18:0] exp_q[$];
    logic [18:0] e;
    logic [15:0] sh, lastd;
    logic [9:0]  offs[4];
    int          nb, err_total, compares, cyc;
    always #5 sys_clk = ~sys_clk;
    rbs_core u_dut (.SYS_CLK(sys_clk), .RST(rst), .CHIP_RESET_N(chip_rst_n),
        .LINK_CLK(link_clk), .LINK_DATA(link_data), .FIX_ENABLE_SELECT(fix),
        .OUT_EDGE_POLARITY_SELECT(pol), .MARKER_SECOND_ONLY(mark), .SER_DATA(ser_data),
        .SER_CLK(ser_clk), .SER_START(ser_start), .RECV_O(recv_o), .RECV_OE(recv_oe),
        .FIX_O(fix_o), .FIX_OE(fix_oe), .UNFIX_O(unfix_o), .UNFIX_OE(unfix_oe),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq));
    rbs_demod_model u_dem (.link_clk(link_clk), .link_data(link_data));
    // ========================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic report_and_stop;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    function automatic logic [9:0] chk(input logic [15:0] d);
        logic [25:0] r;
        r = {d, 10'h000};
        for (int i = 25; i >= 10; i--) if (r[i]) r[i -: 11] ^= {1'b1, rbs_pkg::GEN_POLY};
        return r[9:0];
    endfunction
    task automatic blk(input int idx, input logic [15:0] d, input logic [25:0] err,
                       input logic out, input logic fx, input logic ufx);
        logic [25:0] w;
        w = {d, chk(d) ^ offs[idx]} ^ err;
        if (out) exp_q.push_back({ufx ? w[25:10] : d, !mark || idx == 1, fx, ufx});
        if (out) lastd = ufx ? w[25:10] : d;
        u_dem.send(w);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; penable <= 1'b0;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle_chk;
        repeat (2) @(posedge sys_clk);
        check("idle", {ser_clk, ser_data, ser_start, recv_oe, fix_oe, unfix_oe, recv_o, fix_o,
                       unfix_o}, 32'h1C0);
    endtask
    task automatic do_reset(input logic f, input logic p, input logic m);
        @(posedge sys_clk);
        rst <= 1'b1; fix <= f; pol <= p; mark <= m;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        idle_chk();
    endtask
    task automatic drain;
        int n = 0;
        // One more link bit closes the last block
        u_dem.tick(1'b0);
        while ((exp_q.size() != 0 || recv_oe) && n < 2000) begin
            @(posedge sys_clk);
            n++;
        end
        check("drain", 32'(exp_q.size()), 32'h0);
    endtask
    // ========================================
    // Serial capture
    always @(posedge sys_clk) begin
        if (!recv_oe) nb = 0;
        if (poe && recv_oe && (pol ? (pclk && !ser_clk) : (!pclk && ser_clk))) begin
            if (nb == 0) mk = !ser_start;
            else if (!ser_start) mk = 1'b0;
            if (nb == 0) e[1:0] = {fix_oe, unfix_oe};
            sh = {sh[14:0], ser_data};
            nb++;
            if (nb == 16 && exp_q.size() == 0) check("extra block", 32'h1, 32'h0);
            else if (nb == 16) check("block", {sh, mk, e[1:0]}, exp_q.pop_front());
            if (nb == 16) nb = 0;
        end
        pclk <= ser_clk;
        poe <= recv_oe;
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            report_and_stop();
        end
    end
    // ========================================
    // Scenarios
    initial begin
        {sys_clk, rst, chip_rst_n, fix, pol, mark} = 6'b011100;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        offs = '{rbs_pkg::OFF_A, rbs_pkg::OFF_B, rbs_pkg::OFF_C, rbs_pkg::OFF_D};
        void'($urandom(29412));
        do_reset(1'b1, 1'b0, 1'b0);
        blk(0, 16'h0000, 26'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 1; i < 6; i++) blk(i % 4, 16'($urandom), 26'h0, 1'b1, 1'b0, 1'b0);
        drain();
        do_reset(1'b1, 1'b1, 1'b1);
        blk(0, 16'h0000, 26'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 1; i < 5; i++)
            blk(i % 4, 16'($urandom), (i == 2) ? 26'h0007000 : 26'h0, 1'b1, i == 2, 1'b0);
        drain();
        apb(1'b0, rbs_pkg::ADDR_STATUS, 32'h0);
        check("status fixed", rd, 32'h5);
        @(posedge sys_clk);
        chip_rst_n <= 1'b0; fix <= 1'b0; pol <= 1'b0; mark <= 1'b0;
        repeat (5) @(posedge sys_clk);
        chip_rst_n <= 1'b1;
        idle_chk();
        blk(0, 16'h0000, 26'h0, 1'b0, 1'b0, 1'b0);
        for (int i = 1; i < 4; i++) blk(i, 16'($urandom), 26'h0, 1'b1, 1'b0, 1'b0);
        for (int i = 0; i < 5; i++) blk(i % 4, 16'($urandom), 26'h0100000, i < 4, 1'b0, i < 4);
        drain();
        repeat (400) @(posedge sys_clk);
        check("recv after loss", 32'(recv_oe), 32'h0);
        apb(1'b1, rbs_pkg::ADDR_MASK, 32'h2);
        repeat (2) @(posedge sys_clk);
        check("irq set", 32'(irq), 32'h1);
        apb(1'b0, rbs_pkg::ADDR_STATUS, 32'h0);
        check("status loss", rd, 32'hB);
        apb(1'b0, rbs_pkg::ADDR_DATA, 32'h0);
        check("last data", rd, 32'(lastd));
        apb(1'b0, rbs_pkg::ADDR_STATE, 32'h0);
        check("state", rd, 32'h12);
        repeat (2) @(posedge sys_clk);
        check("irq clear", 32'(irq), 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped", {rd[30:0], er}, 32'h1);
        apb(1'b0, rbs_pkg::ADDR_MASK, 32'h0);
        check("mask", {rd[30:0], er}, 32'h4);
        report_and_stop();
    end
endmodule
